//--- shared/osw_cfg.svh
// Purpose: constants of the output switch and over-current frame block
// Assumes: 100 MHz system clock, 24-bit serial frames
// Notes: offsets are bit positions inside the command and status frames
`ifndef OSW_CFG_SVH
`define OSW_CFG_SVH

// ==========================================================
// frame layout
`define OSW_FRAME_BITS 24
`define OSW_CNT_LAST 5'h17
`define OSW_BIT_ENABLE 23
`define OSW_BIT_RESET 22
`define OSW_BIT_DUTY 21
`define OSW_BIT_ALWAYS_ONE 23
`define OSW_DRV_MSB 17
// driver bits that exist: 17, 15, 14 and 10 down to 1
`define OSW_DRV_MASK 18'h2C7FE
`define OSW_CMD_RESET 24'h000000
`define OSW_STATUS_RESET 24'h800001

// ==========================================================
// recovery timing
`define OSW_CLK_MHZ 100
`define OSW_REC_PERIOD_NS 1000
`define OSW_REC_PERIOD_CYC ((`OSW_REC_PERIOD_NS * `OSW_CLK_MHZ) / 1000)
`define OSW_DUTY_LO_PCT 12
`define OSW_DUTY_HI_PCT 25
`define OSW_ON_LO_CYC ((`OSW_REC_PERIOD_CYC * `OSW_DUTY_LO_PCT) / 100)
`define OSW_ON_HI_CYC ((`OSW_REC_PERIOD_CYC * `OSW_DUTY_HI_PCT) / 100)

`endif

//--- shared/osw_pkg.sv
// Purpose: shared types of the output switch and over-current frame block
// Assumes: nothing beyond the constants header
// Notes: widths follow the 24-bit frame and 18 driver positions
package osw_pkg;
  // ==========================================================
  // types
  typedef logic [23:0] osw_word_t; // one serial frame
  typedef logic [17:0] osw_drv_t; // one bit per driver position
  typedef logic [6:0] osw_phase_t; // recovery phase counter
endpackage : osw_pkg

//--- rtl/osw_spi_link.sv
// Purpose: serial shifter running on the link clock
// Assumes: frames of exactly 24 bits, data changes on rising and is sampled on falling edge
// Notes: status word must stay stable while chip select is low
`timescale 1ns/10ps
`include "osw_cfg.svh"

module osw_spi_link (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  input wire logic i_csn_n,
  input wire logic i_mosi,
  input wire osw_pkg::osw_word_t i_status,
  output osw_pkg::osw_word_t o_rx_word,
  output logic o_rx_toggle,
  output logic o_miso
);
  import osw_pkg::*;

  // ==========================================================
  // reset crossing into the link domain
  logic rst_meta_r; // first stage, read by the second stage only
  logic rst_n_r; // link-side reset level
  always_ff @(posedge i_link_clk) begin
    rst_meta_r <= i_rst_n;
    rst_n_r <= rst_meta_r;
  end

  // ==========================================================
  // receive side, falling edge
  logic [4:0] cnt_r, cnt_nxt; // bit position inside the frame
  osw_word_t rx_r, rx_nxt; // incoming shift register
  osw_word_t word_r, word_nxt; // last complete frame
  logic tog_r, tog_nxt; // flips once per complete frame

  // next values of the receive side
  always_comb begin
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    word_nxt = word_r;
    tog_nxt = tog_r;
    if (!rst_n_r) begin
      cnt_nxt = 5'h00;
      rx_nxt = '0;
      word_nxt = '0;
      tog_nxt = 1'b0;
    end else if (!i_csn_n) begin
      rx_nxt = {rx_r[22:0], i_mosi};
      if (cnt_r == `OSW_CNT_LAST) begin
        // the word is stable for a whole frame, long enough for the other side
        cnt_nxt = 5'h00;
        word_nxt = {rx_r[22:0], i_mosi};
        tog_nxt = ~tog_r;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  // registers of the receive side
  always_ff @(negedge i_link_clk) begin
    cnt_r <= cnt_nxt;
    rx_r <= rx_nxt;
    word_r <= word_nxt;
    tog_r <= tog_nxt;
  end

  // ==========================================================
  // transmit side, rising edge
  osw_word_t tx_r, tx_nxt; // outgoing shift register
  logic miso_r, miso_nxt; // data line to the controller

  // next values of the transmit side
  always_comb begin
    tx_nxt = tx_r;
    miso_nxt = miso_r;
    if (!rst_n_r) begin
      tx_nxt = '0;
      miso_nxt = 1'b0;
    end else if (!i_csn_n) begin
      if (cnt_r == 5'h00) begin
        // snapshot the frozen status at the first edge of a frame
        miso_nxt = i_status[23];
        tx_nxt = {i_status[22:0], 1'b0};
      end else begin
        miso_nxt = tx_r[23];
        tx_nxt = {tx_r[22:0], 1'b0};
      end
    end
  end

  // registers of the transmit side
  always_ff @(posedge i_link_clk) begin
    tx_r <= tx_nxt;
    miso_r <= miso_nxt;
  end

  assign o_rx_word = word_r;
  assign o_rx_toggle = tog_r;
  assign o_miso = miso_r;
endmodule : osw_spi_link

//--- rtl/osw_frame_top.sv
// Purpose: driver switching and over-current status of the first frame pair
// Assumes: second-frame settings arrive as same-clock inputs; pins pass two flip-flops
// Notes: status is frozen while chip select is low so the link reads a steady word
`timescale 1ns/10ps
`include "osw_cfg.svh"

module osw_frame_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_csn_n,
  input wire logic i_mosi,
  input wire logic i_gate_input_a,
  input wire logic i_gate_input_b,
  input wire osw_pkg::osw_drv_t i_overcurrent,
  input wire osw_pkg::osw_drv_t i_pwm_enable,
  input wire osw_pkg::osw_drv_t i_pwm_select_b,
  input wire osw_pkg::osw_drv_t i_recovery_enable,
  output osw_pkg::osw_drv_t o_drive,
  output logic o_standby,
  output logic o_miso
);
  import osw_pkg::*;

  // ==========================================================
  // helpers
  // clear both switches of any half bridge asked to be on at once
  function automatic osw_drv_t osw_interlock(input osw_drv_t want);
    osw_drv_t res;
    res = want;
    for (int k = 0; k < 5; k++) begin
      if (want[2 * k + 2] && want[2 * k + 1]) begin
        res[2 * k + 2] = 1'b0;
        res[2 * k + 1] = 1'b0;
      end
    end
    return res;
  endfunction : osw_interlock

  // true when any half bridge has both switches on
  function automatic logic osw_conflict(input osw_drv_t drv);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 5; k++) begin
      hit = hit | (drv[2 * k + 2] & drv[2 * k + 1]);
    end
    return hit;
  endfunction : osw_conflict

  // ==========================================================
  // link side
  osw_word_t status_r, status_nxt; // frozen status word for the link
  osw_word_t rx_word; // last command frame, link domain
  logic rx_toggle; // frame-complete toggle, link domain

  osw_spi_link u_link (
    .i_link_clk(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_csn_n(i_csn_n),
    .i_mosi(i_mosi),
    .i_status(status_r),
    .o_rx_word(rx_word),
    .o_rx_toggle(rx_toggle),
    .o_miso(o_miso)
  );

  // ==========================================================
  // input synchronisers
  logic [1:0] gate_meta_r, gate_s_r; // gate inputs a and b
  osw_drv_t oc_meta_r, oc_s_r; // over-current comparators
  logic tog_meta_r, tog_s_r; // frame toggle
  logic csn_meta_r, csn_s_r; // chip select level

  // two flip-flops per pin, the first read only by the second
  always_ff @(posedge i_clock) begin
    gate_meta_r <= {i_gate_input_b, i_gate_input_a};
    gate_s_r <= gate_meta_r;
    oc_meta_r <= i_overcurrent;
    oc_s_r <= oc_meta_r;
    tog_meta_r <= rx_toggle;
    tog_s_r <= tog_meta_r;
    csn_meta_r <= i_csn_n;
    csn_s_r <= csn_meta_r;
  end

  // ==========================================================
  // command, fault and drive state
  osw_word_t cmd_r, cmd_nxt; // stored command frame
  osw_drv_t flag_r, flag_nxt; // latched over-current flags
  osw_drv_t blk_r, blk_nxt; // driver held off after a fault
  osw_drv_t drive_r, drive_nxt; // switch commands to the stages
  osw_phase_t phase_r, phase_nxt; // recovery period counter
  logic seen_r, seen_nxt; // last toggle value taken
  logic apply_r, apply_nxt; // a frame was taken last cycle
  logic apply; // a new frame is ready this cycle
  logic clr; // flags cleared by reset bit or standby
  logic wrap; // recovery period restarts
  logic on_win; // retry window of the recovery period
  osw_drv_t ev; // fault events on existing drivers
  osw_drv_t pwm_ok; // gate condition per driver
  osw_drv_t want; // drivers asked on before interlock

  assign apply = (tog_s_r != seen_r);
  assign ev = oc_s_r & `OSW_DRV_MASK;

  // next values of command, fault and drive state
  always_comb begin
    cmd_nxt = cmd_r;
    seen_nxt = tog_s_r;
    apply_nxt = apply;
    clr = 1'b0;
    // a frame without the enable bit drops to standby and clears all
    if (apply) begin
      if (rx_word[`OSW_BIT_ENABLE]) begin
        cmd_nxt = rx_word & {6'h3F, `OSW_DRV_MASK};
        clr = rx_word[`OSW_BIT_RESET];
      end else begin
        cmd_nxt = `OSW_CMD_RESET;
        clr = 1'b1;
      end
    end
    // free-running period; a driver without recovery is never retried here,
    // which stays inside the one-retry tolerance the controller must accept
    wrap = (phase_r == 7'(`OSW_REC_PERIOD_CYC - 1));
    phase_nxt = wrap ? 7'h00 : phase_r + 7'h01;
    on_win = cmd_r[`OSW_BIT_DUTY] ? (phase_r < 7'(`OSW_ON_HI_CYC)) : (phase_r < 7'(`OSW_ON_LO_CYC));
    // an event in the clearing cycle still lands
    flag_nxt = (flag_r & ~{18{clr}}) | ev;
    blk_nxt = blk_r;
    for (int i = 0; i <= `OSW_DRV_MSB; i++) begin
      if (ev[i]) begin
        blk_nxt[i] = 1'b1;
      end else if (clr) begin
        blk_nxt[i] = 1'b0;
      end else if (wrap && i_recovery_enable[i]) begin
        blk_nxt[i] = 1'b0;
      end
    end
    for (int i = 0; i <= `OSW_DRV_MSB; i++) begin
      pwm_ok[i] = !i_pwm_enable[i] || (i_pwm_select_b[i] ? gate_s_r[1] : gate_s_r[0]);
    end
    want = cmd_r[17:0] & `OSW_DRV_MASK & pwm_ok & ~blk_r;
    // a recovering driver may only conduct inside the duty window
    want = want & ~(flag_r & i_recovery_enable & {18{~on_win}});
    want = want & {18{cmd_r[`OSW_BIT_ENABLE]}};
    // both switches off rather than guessing which one wins
    drive_nxt = osw_interlock(want) & ~ev;
  end

  // registers of command, fault and drive state
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmd_r <= `OSW_CMD_RESET;
      flag_r <= '0;
      blk_r <= '0;
      drive_r <= '0;
      phase_r <= 7'h00;
      seen_r <= 1'b0;
      apply_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      flag_r <= flag_nxt;
      blk_r <= blk_nxt;
      drive_r <= drive_nxt;
      phase_r <= phase_nxt;
      seen_r <= seen_nxt;
      apply_r <= apply_nxt;
    end
  end

  // ==========================================================
  // status word, frozen during a frame
  logic standby_r, standby_nxt; // device not enabled

  // the link snapshots the word at its first edge, so it must not move then
  always_comb begin
    status_nxt = status_r;
    standby_nxt = !cmd_nxt[`OSW_BIT_ENABLE];
    if (csn_s_r) begin
      status_nxt = '0;
      status_nxt[`OSW_BIT_ALWAYS_ONE] = 1'b1;
      status_nxt[17:0] = flag_r & `OSW_DRV_MASK;
      status_nxt[0] = ~|status_nxt[22:1];
    end
  end

  // registers of the status word
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      status_r <= `OSW_STATUS_RESET;
      standby_r <= 1'b1;
    end else begin
      status_r <= status_nxt;
      standby_r <= standby_nxt;
    end
  end

  assign o_drive = drive_r;
  assign o_standby = standby_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence frame_taken;
    apply_r;
  endsequence

  sequence standby_frame;
    apply && !rx_word[`OSW_BIT_ENABLE];
  endsequence

  // checked on the registered drive, which is what the output stages see
  bridge_no_overlap_a: assert property (!osw_conflict(drive_r))
    else $error("half bridge high and low both on");

  // an event reaches the flag and the drive in the same following cycle
  oc_turns_off_a: assert property ((|ev) |=> ((drive_r & $past(ev)) == '0))
    else $error("driver still on after over-current");

  oc_sets_flag_a: assert property ((|ev) |=> ((flag_r & $past(ev)) == $past(ev)))
    else $error("over-current flag not set");

  // no driver conducts without its stored command bit
  drive_needs_cmd_a: assert property ((drive_r & ~$past(cmd_r[17:0])) == '0)
    else $error("driver on without command bit");

  // gated drivers follow their selected gate input one cycle late
  pwm_gate_held_a: assert property ((drive_r & ~$past(pwm_ok)) == '0)
    else $error("pwm driver on while gate input low");

  // a recovering driver conducts only inside the duty window
  recovery_window_a: assert property ((drive_r & $past(flag_r & i_recovery_enable) & ~{18{$past(on_win)}}) == '0)
    else $error("recovering driver on outside duty window");

  // a standby frame empties the command, then the drive
  standby_clears_a: assert property (standby_frame |=> frame_taken ##0 (cmd_r == '0) ##1 (drive_r == '0))
    else $error("standby did not clear command and drivers");

  // the summary bit reads one only with every flag clear
  no_error_bit_a: assert property (csn_s_r |=> (status_r[0] == ~|$past(flag_r & `OSW_DRV_MASK)))
    else $error("no-error bit wrong");

  spare_bits_zero_a: assert property ((cmd_r[16] | cmd_r[13] | cmd_r[12] | cmd_r[11]
    | status_r[16] | status_r[13] | status_r[12]) == 1'b0)
    else $error("spare bit not zero");

  // without recovery only a clear lifts a block, on every driver
  no_recovery_hold_a: assert property ((~blk_r & $past(blk_r & ~i_recovery_enable)
    & ~{18{$past(clr)}}) == '0)
    else $error("blocked driver released without reset bit");

  // ==========================================================
  // further checks
  sequence period_wrap;
    wrap && !clr;
  endsequence

  sequence enabled_frame;
    apply && rx_word[`OSW_BIT_ENABLE];
  endsequence

  // a wrap releases every recovering driver that has no fresh event
  recovery_release_a: assert property (period_wrap |=> ((blk_r & $past(i_recovery_enable & ~ev)) == '0))
    else $error("recovering driver not released at period end");

  // a taken frame lands on the existing driver bits only
  frame_lands_a: assert property (enabled_frame |=>
    frame_taken ##0 (cmd_r[17:0] == ($past(rx_word[17:0]) & `OSW_DRV_MASK)))
    else $error("command bits not taken from frame");

  // flags only fall in a clearing cycle; without one every flag holds
  flag_holds_a: assert property (!clr |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
    else $error("over-current flag lost without a clear");

  // a blocked driver stays off until its block is lifted
  blocked_off_a: assert property ((drive_r & $past(blk_r)) == '0)
    else $error("blocked driver switched on");

  // between frames the status word carries the latched flags
  status_flags_a: assert property (csn_s_r |=> ((status_r[17:0] & `OSW_DRV_MASK) == $past(flag_r & `OSW_DRV_MASK)))
    else $error("status flags differ from latched flags");

  status_upper_a: assert property (csn_s_r |=> (status_r[23:18] == 6'h20))
    else $error("fixed upper status bits wrong");

  // standby output follows the stored enable bit, drivers stay off
  standby_tracks_a: assert property (standby_r == !cmd_r[`OSW_BIT_ENABLE])
    else $error("standby output differs from enable bit");

  standby_off_a: assert property (!cmd_r[`OSW_BIT_ENABLE] |=> (drive_r == '0))
    else $error("driver on in standby");
endmodule : osw_frame_top

//--- tb/osw_mcu_model.sv
// Purpose: controller model that is the master of the serial frame link
// Assumes: link clock 30 ns, idle low, still between frames
// Notes: mosi shows the inverse of its last bit once released, as it has no pull
`timescale 1ns/10ps

module osw_mcu_model (
  output logic o_link_clk,
  output logic o_csn_n,
  output logic o_mosi,
  input wire logic i_miso
);
  import osw_pkg::*;

  // ==========================================
  // idle levels
  initial begin
    o_link_clk = 1'b0;
    o_csn_n = 1'b1;
    o_mosi = 1'b0;
  end

  // ==========================================
  // clock pulses with select high, only to flush the link reset
  task automatic pulse(input int n);
    repeat (n) begin
      #15 o_link_clk = 1'b1;
      #15 o_link_clk = 1'b0;
    end
  endtask : pulse

  // ==========================================
  // one whole 24-bit frame, msb first; status taken after each falling edge
  task automatic xfer(input osw_word_t cmd, output osw_word_t sts);
    o_csn_n = 1'b0;
    #20; // let the device freeze its status before the first edge
    for (int i = 23; i >= 0; i--) begin
      o_mosi = cmd[i];
      #14 o_link_clk = 1'b1; // device launches status bit
      #15 o_link_clk = 1'b0; // device samples command bit
      #1 sts[i] = i_miso;
    end
    #5 o_csn_n = 1'b1;
    o_mosi = ~cmd[0];
    #60; // gap lets the status snapshot refresh
  endtask : xfer
endmodule : osw_mcu_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the output switch and over-current frame
// Assumes: 100 MHz system clock, inputs driven at its falling edge
// Notes: status read in a frame is the snapshot taken when that frame starts
`timescale 1ns/10ps
`include "osw_cfg.svh"

module testbench;
  import osw_pkg::*;

  // ==========================================
  // signals
  logic i_clock, i_rst_n, link_clk, csn_n, mosi, miso, standby, gate_a, gate_b;
  osw_drv_t oc, pwm_en, pwm_b, rec_en, drive;
  osw_word_t sts; // status seen in the last frame
  int fails = 0;
  int check_count = 0;
  int on_cnt;
  localparam osw_word_t EN = 24'h800000; // enable
  localparam osw_word_t CLR = 24'h400000; // flag clear
  localparam osw_word_t DUTY = 24'h200000; // long retry duty
  localparam osw_word_t HS = 24'h02C554; // every high side
  localparam osw_word_t LS = 24'h0002AA; // every low side
  localparam osw_word_t SPARE = 24'h013800; // don't-care bits

  osw_frame_top uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clk(link_clk), .i_csn_n(csn_n),
    .i_mosi(mosi), .i_gate_input_a(gate_a), .i_gate_input_b(gate_b), .i_overcurrent(oc),
    .i_pwm_enable(pwm_en), .i_pwm_select_b(pwm_b), .i_recovery_enable(rec_en), .o_drive(drive),
    .o_standby(standby), .o_miso(miso));
  osw_mcu_model mcu (.o_link_clk(link_clk), .o_csn_n(csn_n), .o_mosi(mosi), .i_miso(miso));

  // ==========================================
  // helpers
  task automatic chk(input osw_word_t seen, input osw_word_t exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic frame(input osw_word_t cmd);
    mcu.xfer(cmd, sts);
    repeat (8) @(negedge i_clock); // apply latency plus margin
  endtask : frame

  task automatic count_on(input int b, input int n);
    on_cnt = 0;
    repeat (n) begin
      @(negedge i_clock);
      if (drive[b] === 1'b1) on_cnt++;
    end
  endtask : count_on

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ==========================================
  // scenarios
  task automatic t_switch();
    frame(EN | HS | SPARE);
    chk({6'h00, drive}, HS);
    chk({23'h0, standby}, 24'h000000);
    frame(EN | LS);
    chk({6'h00, drive}, LS);
    frame(EN | HS | LS);
    chk({6'h00, drive}, 24'h02C000);
  endtask : t_switch

  task automatic t_pwm();
    @(negedge i_clock);
    pwm_en[17] = 1'b1;
    frame(EN | 24'h020000);
    chk({6'h00, drive}, 24'h000000);
    gate_a = 1'b1;
    repeat (5) @(negedge i_clock);
    chk({6'h00, drive}, 24'h020000);
    pwm_b[17] = 1'b1;
    repeat (5) @(negedge i_clock);
    chk({6'h00, drive}, 24'h000000);
    gate_b = 1'b1;
    repeat (5) @(negedge i_clock);
    chk({6'h00, drive}, 24'h020000);
    pwm_en[17] = 1'b0;
  endtask : t_pwm

  task automatic t_oc_latched();
    frame(EN | 24'h004000);
    oc[14] = 1'b1;
    repeat (6) @(negedge i_clock);
    chk({6'h00, drive}, 24'h000000);
    oc[14] = 1'b0;
    count_on(14, 300);
    chk({23'h0, on_cnt <= `OSW_ON_HI_CYC}, 24'h000001);
    frame(EN | 24'h004000);
    chk(sts, 24'h804000);
    frame(EN | CLR | 24'h004000);
    frame(EN | 24'h004000);
    chk(sts, 24'h800001);
    chk({6'h00, drive}, 24'h004000);
  endtask : t_oc_latched

  task automatic t_recovery();
    rec_en[15] = 1'b1;
    frame(EN | 24'h008000);
    oc[15] = 1'b1;
    repeat (5) @(negedge i_clock);
    oc[15] = 1'b0;
    repeat (200) @(negedge i_clock);
    count_on(15, 1000);
    chk(on_cnt, `OSW_ON_LO_CYC * 10);
    frame(EN | DUTY | 24'h008000);
    chk(sts, 24'h808000);
    repeat (200) @(negedge i_clock);
    count_on(15, 1000);
    chk(on_cnt, `OSW_ON_HI_CYC * 10);
    rec_en[15] = 1'b0;
    frame(EN | CLR);
  endtask : t_recovery

  task automatic t_standby();
    frame(EN | HS);
    oc[2] = 1'b1;
    repeat (6) @(negedge i_clock);
    oc[2] = 1'b0;
    frame(24'h000000);
    chk(sts, 24'h800004);
    chk({6'h00, drive}, 24'h000000);
    chk({23'h0, standby}, 24'h000001);
    frame(EN);
    chk(sts, 24'h800001);
  endtask : t_standby

  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    give_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    gate_a = 1'b0;
    gate_b = 1'b0;
    oc = '0;
    pwm_en = '0;
    pwm_b = '0;
    rec_en = '0;
    mcu.pulse(2); // link reset needs link edges while reset is low
    repeat (16) @(negedge i_clock);
    chk({6'h00, drive}, 24'h000000);
    chk({23'h0, standby}, 24'h000001);
    i_rst_n = 1'b1;
    mcu.pulse(3); // link-side reset release needs link edges too
    repeat (2) @(negedge i_clock);
    frame(24'h000000);
    chk(sts, 24'h800001);
    t_switch();
    t_pwm();
    t_oc_latched();
    t_recovery();
    t_standby();
    give_verdict();
  end
endmodule : testbench
